// File: sensor_cfg_pkg.sv
// shared constants, types and carriers of the sensor readout configuration bank
package sensor_cfg_pkg;
	localparam int DATA_W = 12;
	localparam int ADDR_W = 4;
	localparam int WORD_W = 10;
	localparam int LAG_DEPTH = 13;
	// register offsets
	localparam logic [3:0] OFS_ROW_COUNT = 4'h2;
	localparam logic [3:0] OFS_EXPOSURE  = 4'h3;
	localparam logic [3:0] OFS_LAG       = 4'h4;
	localparam logic [3:0] OFS_COL_START = 4'h5;
	localparam logic [3:0] OFS_ROW_START = 4'h6;
	localparam logic [3:0] OFS_CORE      = 4'h7;
	localparam logic [3:0] OFS_AMP       = 4'h8;
	localparam logic [3:0] OFS_COARSE    = 4'h9;
	localparam logic [3:0] OFS_TRIM      = 4'hA;
	localparam logic [3:0] OFS_BLACK     = 4'hB;
	localparam logic [3:0] OFS_CONV      = 4'hC;
	// reset values
	localparam logic [11:0] RST_ROW_COUNT = 12'hBC6;
	localparam logic [11:0] RST_EXPOSURE  = 12'h001;
	localparam logic [7:0]  RST_LAG       = 8'h03;
	localparam logic [6:0]  RST_COL_START = 7'h00;
	localparam logic [7:0]  RST_ROW_START = 8'h00;
	localparam logic [7:0]  RST_CORE      = 8'h00;
	localparam logic [9:0]  RST_AMP       = 10'h010;
	localparam logic [7:0]  RST_DAC       = 8'h80;
	localparam logic [10:0] RST_CONV      = 11'h000;
	// field positions
	localparam int LAG_QUAL_LSB = 0;
	localparam int LAG_END_LSB  = 4;
	localparam logic [3:0] LAG_FREE_MAX = 4'h2;
	localparam int TEST_LSB = 0;
	localparam int XSUB_LSB = 2;
	localparam int YSUB_LSB = 5;
	localparam int GAIN_LSB = 0;
	localparam int UNITY_BIT = 4;
	localparam int ONE_OUT_BIT = 5;
	localparam int AMP_STBY_BIT = 6;
	localparam int AMP_LAG_LSB = 7;
	localparam int CONV_STBY_LSB = 0;
	localparam int NO_INTERLEAVE_BIT = 2;
	localparam int SWITCH_BIT = 3;
	localparam int CLK_SRC_BIT = 4;
	localparam int DRIVE_OFF_BIT = 5;
	localparam int CONV_LAG_LSB = 6;
	localparam int GAMMA_BIT = 9;
	localparam int FLIP_BIT = 10;
	// nondestructive sub-mode codes: bit 1 picks mode 2, bit 0 picks the read frame
	localparam logic [1:0] ND_M1_RESET = 2'b00;
	localparam logic [1:0] ND_M1_READ  = 2'b01;
	localparam logic [1:0] ND_M2_RESET = 2'b10;
	localparam logic [1:0] ND_M2_READ  = 2'b11;
	localparam int ND_MODE2_BIT = 1;
	localparam int ND_READ_BIT  = 0;

	typedef enum logic [3:0] {
		PH_IDLE     = 4'b0001,
		PH_SAMPLE_A = 4'b0010,
		PH_RESET    = 4'b0100,
		PH_SAMPLE_B = 4'b1000
	} row_phase_t;

	typedef struct packed {
		logic [3:0] gain;
		logic       unity;
		logic       one_out;
		logic       standby;
		logic [2:0] amp_clock_lag;
	} amp_ctrl_t;

	typedef struct packed {
		logic [1:0] standby;
		logic       interleave;
		logic       delay_full;
		logic       delay_half;
		logic       second_conv;
		logic       converter_clock_src;
		logic       drive_off;
		logic [2:0] clock_lag;
		logic       gamma;
		logic       word_polarity_flip;
	} conv_ctrl_t;

	typedef struct packed {
		logic sample_a;
		logic row_reset;
		logic sample_b;
		logic read_left;
		logic read_right;
		logic both_sides;
		logic left_load;
		logic right_pointer_load;
	} row_ops_t;
endpackage : sensor_cfg_pkg

// File: sensor_readout_config_bank.sv
// configuration register bank and row sequencing of the sensor readout
// Overview of operation
// R1: 12-bit row count limit per frame, up to 3014 lines.
// R2: lag register low nibble delays qualifier, high nibble delays end pulses.
// R3: 7-bit column window start, software keeps it within 0..98.
// R4: 8-bit row window start loads the row pointers, range 0..137.
// R5: core register: test select 1:0, column subsample 4:2, row subsample 7:5.
// R6: amplifier gain code bits 3:0; bit 4 forces unity gain.
// R7: amplifier bit 5 multiplexes both streams onto the first output.
// R8: amplifier bit 6 standby; bits 9:7 select amplifier clock lag.
// R9: three 8-bit offset registers reset to mid-scale 0x80.
// R10: converter bit 2 clear interleaves both converters into one stream.
// R11: bit 3 delays interleaved output, or picks converter when not interleaved.
// R12: converter bit 4 selects external converter clock instead of internal.
// R13: converter bit 5 puts digital output pins in high impedance.
// R14: converter bits 8:6 select converter and multiplexer clock lag.
// R15: converter bit 9 selects gamma-law instead of linear conversion.
// R16: converter bit 10 inverts every bit of the output word.
// R17: normal readout samples, resets row, samples again, then subtracts.
// R18: 2-bit sub-mode acts only in nondestructive readout; four settings.
// R19: mode 1 drives left and right pointers identically, no shutter.
// R20: mode 2 alternates row readouts between left and right pointers.
// R21: mode 2 reset frame resets left row only; read frame never resets.
// R22: lag codes 0..2 add nothing, higher codes add code minus two.
// R23: after frame start count row advances; at exposure value load right pointer.
// R24: controller supplies clock, frame start and row advance pulses.
// R25: nondestructive readout holds reset buses at the dark reference level.
// R26: writes to reserved addresses 13..15 are ignored.
module sensor_readout_config_bank
	import sensor_cfg_pkg::*;
(
	// clock and reset
	input  wire logic                               ref_clk,
	input  wire logic                               resetn,
	// parallel load port from the serial deserializer
	input  wire logic                               cfg_wr_en,
	input  wire logic [sensor_cfg_pkg::ADDR_W-1:0]  cfg_addr,
	input  wire logic [sensor_cfg_pkg::DATA_W-1:0]  cfg_wr_data,
	output logic      [sensor_cfg_pkg::DATA_W-1:0]  cfg_rd_data,
	// readout mode from the main sequencer register
	input  wire logic                               nondestructive_sel,
	input  wire logic [1:0]                         nd_submode,
	// controller pins
	input  wire logic                               frame_start_pin,
	input  wire logic                               row_advance_pin,
	// pixel sequencer and converter, same clock
	input  wire logic                               qualifier_raw,
	input  wire logic                               row_end_raw,
	input  wire logic [sensor_cfg_pkg::WORD_W-1:0]  conv_word,
	// timing pulses
	output logic                                    sample_qualifier,
	output logic                                    row_end_pulse,
	output logic                                    frame_end_pulse,
	output sensor_cfg_pkg::row_ops_t                row_ops,
	// static controls
	output logic      [11:0]                        row_count_limit,
	output logic      [6:0]                         col_window_start,
	output logic      [7:0]                         row_window_start,
	output logic      [7:0]                         core_readout_cfg,
	output sensor_cfg_pkg::amp_ctrl_t               amp_ctrl,
	output sensor_cfg_pkg::conv_ctrl_t              conv_ctrl,
	output logic      [7:0]                         coarse_offset,
	output logic      [7:0]                         trim_offset,
	output logic      [7:0]                         reset_bus_level,
	output logic                                    reset_bus_dark,
	// digital output pins
	output logic      [sensor_cfg_pkg::WORD_W-1:0]  dout_o,
	output logic                                    dout_oe_n
);
	import sensor_cfg_pkg::*;

	typedef struct packed {
		logic [11:0]          row_count;
		logic [11:0]          exposure;
		logic [7:0]           lag;
		logic [6:0]           col_start;
		logic [7:0]           row_start;
		logic [7:0]           core;
		logic [9:0]           amp;
		logic [7:0]           coarse;
		logic [7:0]           trim;
		logic [7:0]           black;
		logic [10:0]          conv;
		logic [DATA_W-1:0]    rd_data;
		logic [1:0]           fs_sync;
		logic [1:0]           ra_sync;
		logic                 fs_prev;
		logic                 ra_prev;
		logic [11:0]          line_cnt;
		logic [11:0]          int_cnt;
		logic                 int_done;
		logic                 half;
		logic                 frame_done;
		row_phase_t           phase;
		row_ops_t             ops;
		logic [LAG_DEPTH-1:0] qual_sh;
		logic [LAG_DEPTH-1:0] row_end_sh;
		logic [LAG_DEPTH-1:0] frame_end_sh;
		logic                 frame_end_raw;
		logic [WORD_W-1:0]    dout;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic fs_rise;
	logic ra_rise;
	logic nd_mode2;
	logic nd_reset_frame;
	logic count_step;
	logic [11:0] line_next;
	logic [11:0] int_next;

	localparam state_t RST_STATE = '{
		row_count: RST_ROW_COUNT, exposure: RST_EXPOSURE, lag: RST_LAG,
		col_start: RST_COL_START, row_start: RST_ROW_START, core: RST_CORE,
		amp: RST_AMP, coarse: RST_DAC, trim: RST_DAC, black: RST_DAC,
		conv: RST_CONV, phase: PH_IDLE, default: '0};

	// lag tap: codes up to LAG_FREE_MAX pass the raw pulse, higher ones a shift stage
	function automatic logic lag_tap(input logic raw, input logic [LAG_DEPTH-1:0] sh,
		input logic [3:0] code);
		logic [3:0] tap;
		tap = code - LAG_FREE_MAX - 4'h1;
		if (code <= LAG_FREE_MAX)
			return raw;
		return sh[tap];
	endfunction : lag_tap

	// pin edges are taken from the second synchroniser stage only
	assign fs_rise = s_q.fs_sync[1] & ~s_q.fs_prev;
	assign ra_rise = s_q.ra_sync[1] & ~s_q.ra_prev;
	assign nd_mode2 = nondestructive_sel & nd_submode[ND_MODE2_BIT];
	assign nd_reset_frame = ~nd_submode[ND_READ_BIT];
	// mode 2 counts once per left/right pair, on the right-pointer advance
	assign count_step = ra_rise & (~nd_mode2 | s_q.half);
	assign line_next = s_q.line_cnt + 12'h001;
	assign int_next = s_q.int_cnt + 12'h001;

	// next-state logic of the whole bank
	always_comb
	begin
		s_d = s_q;
		s_d.ops = '0;
		s_d.frame_end_raw = 1'b0;
		s_d.fs_sync = {s_q.fs_sync[0], frame_start_pin};
		s_d.ra_sync = {s_q.ra_sync[0], row_advance_pin};
		s_d.fs_prev = s_q.fs_sync[1];
		s_d.ra_prev = s_q.ra_sync[1];

		// R26: reserved and out-of-block offsets fall through untouched
		if (cfg_wr_en)
		begin
			unique case (cfg_addr)
				// R1: row count limit
				OFS_ROW_COUNT: s_d.row_count = cfg_wr_data;
				OFS_EXPOSURE:  s_d.exposure = cfg_wr_data;
				// R2: lag nibbles
				OFS_LAG:       s_d.lag = cfg_wr_data[7:0];
				// R3: column start stored as written
				OFS_COL_START: s_d.col_start = cfg_wr_data[6:0];
				// R4: row start stored as written
				OFS_ROW_START: s_d.row_start = cfg_wr_data[7:0];
				// R5: core readout fields
				OFS_CORE:      s_d.core = cfg_wr_data[7:0];
				OFS_AMP:       s_d.amp = cfg_wr_data[9:0];
				// R9: offset converters
				OFS_COARSE:    s_d.coarse = cfg_wr_data[7:0];
				OFS_TRIM:      s_d.trim = cfg_wr_data[7:0];
				OFS_BLACK:     s_d.black = cfg_wr_data[7:0];
				OFS_CONV:      s_d.conv = cfg_wr_data[10:0];
				default:       s_d.rd_data = s_q.rd_data;
			endcase
		end

		// read-back of the addressed register, zero elsewhere
		unique case (cfg_addr)
			OFS_ROW_COUNT: s_d.rd_data = s_q.row_count;
			OFS_EXPOSURE:  s_d.rd_data = s_q.exposure;
			OFS_LAG:       s_d.rd_data = {4'h0, s_q.lag};
			OFS_COL_START: s_d.rd_data = {5'h00, s_q.col_start};
			OFS_ROW_START: s_d.rd_data = {4'h0, s_q.row_start};
			OFS_CORE:      s_d.rd_data = {4'h0, s_q.core};
			OFS_AMP:       s_d.rd_data = {2'h0, s_q.amp};
			OFS_COARSE:    s_d.rd_data = {4'h0, s_q.coarse};
			OFS_TRIM:      s_d.rd_data = {4'h0, s_q.trim};
			OFS_BLACK:     s_d.rd_data = {4'h0, s_q.black};
			OFS_CONV:      s_d.rd_data = {1'b0, s_q.conv};
			default:       s_d.rd_data = 12'h000;
		endcase

		// R17: double-sampling phases walk one per clock after a row advance
		unique case (s_q.phase)
			PH_IDLE:     s_d.phase = PH_IDLE;
			PH_SAMPLE_A: s_d.phase = PH_RESET;
			PH_RESET:    s_d.phase = PH_SAMPLE_B;
			PH_SAMPLE_B: s_d.phase = PH_IDLE;
		endcase
		s_d.ops.sample_a = (s_q.phase == PH_SAMPLE_A);
		s_d.ops.sample_b = (s_q.phase == PH_SAMPLE_B);
		s_d.ops.row_reset = (s_q.phase == PH_RESET);

		if (ra_rise)
		begin
			if (!nondestructive_sel)
			begin
				// R17: normal readout starts the sample, reset, sample walk
				s_d.phase = PH_SAMPLE_A;
				s_d.ops.read_left = 1'b1;
			end
			else if (!nd_mode2)
			begin
				// R19: mode 1 drives both pointers alike
				s_d.ops.both_sides = 1'b1;
				s_d.ops.read_left = 1'b1;
				s_d.ops.read_right = 1'b1;
				// R18: reset frame resets in the same cycle as the read, read frame never
				s_d.ops.row_reset = nd_reset_frame;
				s_d.ops.sample_a = 1'b1;
			end
			else
			begin
				// R20: alternate left and right pointer on each advance
				s_d.half = ~s_q.half;
				s_d.ops.read_left = ~s_q.half;
				s_d.ops.read_right = s_q.half;
				// R21: only the left row of a reset frame is reset
				s_d.ops.row_reset = nd_reset_frame & ~s_q.half;
				s_d.ops.sample_a = 1'b1;
			end
		end

		// R23: line and exposure counters run on the row advances
		if (count_step && !s_q.frame_done)
		begin
			s_d.line_cnt = line_next;
			if (line_next == s_q.row_count)
			begin
				s_d.frame_done = 1'b1;
				s_d.frame_end_raw = 1'b1;
			end
			if (!s_q.int_done)
			begin
				s_d.int_cnt = int_next;
				if (int_next == s_q.exposure)
				begin
					s_d.int_done = 1'b1;
					s_d.ops.right_pointer_load = ~(nondestructive_sel & ~nd_mode2);
				end
			end
		end

		// R23: frame start restarts the counters and loads the left pointer
		if (fs_rise)
		begin
			s_d.line_cnt = 12'h000;
			s_d.int_cnt = 12'h000;
			s_d.int_done = 1'b0;
			s_d.half = 1'b0;
			s_d.frame_done = 1'b0;
			s_d.ops.left_load = 1'b1;
			// R19: mode 1 loads the right pointer together with the left
			s_d.ops.right_pointer_load = nondestructive_sel & ~nd_mode2;
		end

		// R22: delay lines for the qualifier and end pulses
		s_d.qual_sh = {s_q.qual_sh[LAG_DEPTH-2:0], qualifier_raw};
		s_d.row_end_sh = {s_q.row_end_sh[LAG_DEPTH-2:0], row_end_raw};
		s_d.frame_end_sh = {s_q.frame_end_sh[LAG_DEPTH-2:0], s_q.frame_end_raw};

		// R16: output word inversion
		s_d.dout = s_q.conv[FLIP_BIT] ? ~conv_word : conv_word;
	end

	// single state register; asynchronous reset loads constants only
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
			s_q <= RST_STATE;
		else
			s_q <= s_d;
	end

	// R2: low nibble steers the qualifier, high nibble both end pulses
	assign sample_qualifier = lag_tap(qualifier_raw, s_q.qual_sh, s_q.lag[LAG_QUAL_LSB +: 4]);
	assign row_end_pulse = lag_tap(row_end_raw, s_q.row_end_sh, s_q.lag[LAG_END_LSB +: 4]);
	assign frame_end_pulse = lag_tap(s_q.frame_end_raw, s_q.frame_end_sh,
		s_q.lag[LAG_END_LSB +: 4]);

	assign row_ops = s_q.ops;
	assign row_count_limit = s_q.row_count;
	assign col_window_start = s_q.col_start;
	assign row_window_start = s_q.row_start;
	assign core_readout_cfg = s_q.core;
	assign coarse_offset = s_q.coarse;
	assign trim_offset = s_q.trim;
	assign cfg_rd_data = s_q.rd_data;

	// R6: raw gain code and the unity override travel side by side
	assign amp_ctrl.gain = s_q.amp[GAIN_LSB +: 4];
	assign amp_ctrl.unity = s_q.amp[UNITY_BIT];
	// R7: single-output multiplexing
	assign amp_ctrl.one_out = s_q.amp[ONE_OUT_BIT];
	// R8: standby and amplifier clock lag
	assign amp_ctrl.standby = s_q.amp[AMP_STBY_BIT];
	assign amp_ctrl.amp_clock_lag = s_q.amp[AMP_LAG_LSB +: 3];

	// R10: interleave is the inverse of the disable bit
	assign conv_ctrl.standby = s_q.conv[CONV_STBY_LSB +: 2];
	assign conv_ctrl.interleave = ~s_q.conv[NO_INTERLEAVE_BIT];
	// R11: switch bit means delay while interleaving, converter pick otherwise
	assign conv_ctrl.delay_full = ~s_q.conv[NO_INTERLEAVE_BIT] & s_q.conv[SWITCH_BIT]
		& ~s_q.conv[CLK_SRC_BIT];
	assign conv_ctrl.delay_half = ~s_q.conv[NO_INTERLEAVE_BIT] & s_q.conv[SWITCH_BIT]
		& s_q.conv[CLK_SRC_BIT];
	assign conv_ctrl.second_conv = s_q.conv[NO_INTERLEAVE_BIT] & s_q.conv[SWITCH_BIT];
	// R12: converter clock source
	assign conv_ctrl.converter_clock_src = s_q.conv[CLK_SRC_BIT];
	assign conv_ctrl.drive_off = s_q.conv[DRIVE_OFF_BIT];
	// R14: converter clock lag
	assign conv_ctrl.clock_lag = s_q.conv[CONV_LAG_LSB +: 3];
	// R15: companding select
	assign conv_ctrl.gamma = s_q.conv[GAMMA_BIT];
	assign conv_ctrl.word_polarity_flip = s_q.conv[FLIP_BIT];

	// R25: in nondestructive readout the reset buses sit at the dark level
	assign reset_bus_dark = nondestructive_sel;
	assign reset_bus_level = s_q.black;

	// R13: pins float when the drive-off bit is set; enable is active low
	assign dout_o = s_q.dout;
	assign dout_oe_n = s_q.conv[DRIVE_OFF_BIT];

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_reserved_write_ignored: assert property ( // R26
		cfg_wr_en && cfg_addr > OFS_CONV |=> $stable(s_q.conv) && $stable(s_q.black))
		else $error("reserved write changed state");
	a_row_count_store: assert property ( // R1
		cfg_wr_en && cfg_addr == OFS_ROW_COUNT |=> row_count_limit == $past(cfg_wr_data))
		else $error("row count limit not stored");
	a_ds_reset_order: assert property ( // R17
		ra_rise && !nondestructive_sel |=> ##1 row_ops.sample_a ##1 row_ops.row_reset
		##1 row_ops.sample_b)
		else $error("double sampling order broken");
	a_mode1_both_sides: assert property ( // R19
		ra_rise && nondestructive_sel && !nd_mode2 |=> row_ops.both_sides
		&& row_ops.read_left && row_ops.read_right)
		else $error("mode 1 pointers differ");
	a_mode2_alternate: assert property ( // R20
		ra_rise && nd_mode2 |=> row_ops.read_left != row_ops.read_right)
		else $error("mode 2 not alternating");
	a_mode2_reset_left: assert property ( // R21
		ra_rise && nd_mode2 && s_q.half |=> !row_ops.row_reset)
		else $error("right pointer row was reset");
	a_lag_zero_pass: assert property ( // R22
		s_q.lag[LAG_QUAL_LSB +: 4] <= LAG_FREE_MAX |-> sample_qualifier == qualifier_raw)
		else $error("free lag code delayed qualifier");
	a_lag_max_delay: assert property ( // R22
		s_q.lag[LAG_END_LSB +: 4] == 4'hF && $stable(s_q.lag) [*8]
		|-> row_end_pulse == $past(row_end_raw, 13))
		else $error("lag 15 not thirteen cycles");
	a_right_load_count: assert property ( // R23
		count_step && !s_q.int_done && !s_q.frame_done && int_next == s_q.exposure
		&& !nondestructive_sel |=> row_ops.right_pointer_load)
		else $error("right pointer load missing");
	a_drive_off_pins: assert property ( // R13
		cfg_wr_en && cfg_addr == OFS_CONV
		|=> dout_oe_n == $past(cfg_wr_data[DRIVE_OFF_BIT]))
		else $error("pin enable does not follow drive-off bit");
	a_word_flip: assert property ( // R16
		s_q.conv[FLIP_BIT] && $stable(s_q.conv) |=> dout_o == ~$past(conv_word))
		else $error("output word not inverted");

	c_frame_end: cover property (frame_end_pulse);
	c_mode2_reset: cover property (ra_rise && nd_mode2 && !s_q.half && nd_reset_frame);
	c_right_load: cover property (row_ops.right_pointer_load && !row_ops.left_load);
	c_ds_walk: cover property (row_ops.sample_a ##1 row_ops.row_reset ##1 row_ops.sample_b);
endmodule : sensor_readout_config_bank

// File: ctrl_model.sv
// camera controller model driving the frame start and row advance pins
module ctrl_model
(
	// clock
	input  wire logic ref_clk,
	// pins toward the sensor
	output logic      frame_start_pin,
	output logic      row_advance_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// pins idle low between pulses
	initial
	begin
		frame_start_pin = 1'h0;
		row_advance_pin = 1'h0;
	end
	// frame and row pulses
	// held two cycles so the two-flop synchroniser always sees the rise
	task automatic pulse(input bit fs);
		@(negedge ref_clk);
		if (fs)
			frame_start_pin = 1'h1;
		else
			row_advance_pin = 1'h1;
		repeat (2) @(negedge ref_clk);
		frame_start_pin = 1'h0;
		row_advance_pin = 1'h0;
	endtask : pulse
endmodule : ctrl_model

// File: test_sensor_readout_config_bank.sv
// self-checking bench of the sensor readout configuration bank
module test_sensor_readout_config_bank
	import sensor_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'h0;
	logic resetn = 1'h0;
	logic cfg_wr_en = 1'h0;
	logic [ADDR_W-1:0] cfg_addr = 4'h0;
	logic [DATA_W-1:0] cfg_wr_data = 12'h000;
	logic nondestructive_sel = 1'h0;
	logic [1:0] nd_submode = 2'h0;
	logic qualifier_raw = 1'h0;
	logic row_end_raw = 1'h0;
	logic [WORD_W-1:0] conv_word = 10'h000;
	logic [DATA_W-1:0] cfg_rd_data;
	logic sample_qualifier, row_end_pulse, frame_end_pulse, reset_bus_dark, dout_oe_n;
	logic frame_start_pin, row_advance_pin;
	row_ops_t row_ops, ops;
	logic [11:0] row_count_limit;
	logic [6:0] col_window_start;
	logic [7:0] row_window_start, core_readout_cfg, coarse_offset, trim_offset, reset_bus_level;
	amp_ctrl_t amp_ctrl;
	conv_ctrl_t conv_ctrl;
	logic [WORD_W-1:0] dout_o;
	logic fe;
	int bad_count, total_checks, cyc, seed, pa, pr, pb, dq, de;
	int reg_m [16];
	int msk [16];

	sensor_readout_config_bank u_dut
	(
		.ref_clk, .resetn, .cfg_wr_en, .cfg_addr, .cfg_wr_data, .cfg_rd_data,
		.nondestructive_sel, .nd_submode, .frame_start_pin, .row_advance_pin,
		.qualifier_raw, .row_end_raw, .conv_word, .sample_qualifier, .row_end_pulse,
		.frame_end_pulse, .row_ops, .row_count_limit, .col_window_start, .row_window_start,
		.core_readout_cfg, .amp_ctrl, .conv_ctrl, .coarse_offset, .trim_offset,
		.reset_bus_level, .reset_bus_dark, .dout_o, .dout_oe_n
	);
	ctrl_model u_ctrl
	(
		.ref_clk, .frame_start_pin, .row_advance_pin
	);

	// 50 ns clock and a hang limit far above the planned run
	always #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one write word; the model keeps only mapped offsets, masked to width
	task automatic wr(input int a, input int d);
		@(negedge ref_clk);
		cfg_wr_en = 1'h1;
		cfg_addr = 4'(a);
		cfg_wr_data = 12'(d);
		@(negedge ref_clk);
		cfg_wr_en = 1'h0;
		if (a >= 2 && a <= 12)
			reg_m[a] = d & msk[a];
	endtask : wr

	// read-back is registered, so it is looked at one cycle after the address
	task automatic rd(input int a);
		@(negedge ref_clk);
		cfg_addr = 4'(a);
		@(negedge ref_clk);
		chk(cfg_rd_data, 16'(reg_m[a]));
	endtask : rd

	// decoded levels, output word and pin drive against the model
	task automatic chk_static;
		logic [10:0] c;
		logic [9:0] m;
		amp_ctrl_t ea;
		conv_ctrl_t ec;
		c = 11'(reg_m[12]);
		m = 10'(reg_m[8]);
		ea = {m[3:0], m[4], m[5], m[6], m[9:7]};
		ec = {c[1:0], ~c[2], ~c[2] & c[3] & ~c[4], ~c[2] & c[3] & c[4], c[2] & c[3], c[4],
			c[5], c[8:6], c[9], c[10]};
		chk(amp_ctrl, ea);
		chk(conv_ctrl, ec);
		chk(row_count_limit, 16'(reg_m[2]));
		chk(col_window_start, 16'(reg_m[5]));
		chk(row_window_start, 16'(reg_m[6]));
		chk(core_readout_cfg, 16'(reg_m[7]));
		chk({coarse_offset, trim_offset}, 16'(reg_m[9] * 256 + reg_m[10]));
		chk(reset_bus_level, 16'(reg_m[11]));
		chk(reset_bus_dark, nondestructive_sel);
		conv_word = 10'($random(seed));
		@(negedge ref_clk);
		chk(dout_o, conv_word ^ {10{c[10]}});
		chk(dout_oe_n, c[5]);
	endtask : chk_static

	// one pin pulse, then twelve cycles of row operations gathered
	task automatic adv(input bit fs);
		ops = '0;
		fe = 1'h0;
		pa = -1;
		pr = -1;
		pb = -1;
		u_ctrl.pulse(fs);
		for (int k = 0; k < 12; k++)
		begin
			@(negedge ref_clk);
			ops = ops | row_ops;
			fe = fe | frame_end_pulse;
			if (row_ops.sample_a === 1'h1)
				pa = k;
			if (row_ops.row_reset === 1'h1)
				pr = k;
			if (row_ops.sample_b === 1'h1)
				pb = k;
		end
	endtask : adv

	// main sequence
	initial
	begin
		seed = 32'h87977FC9;
		msk = '{0, 0, 12'hFFF, 12'hFFF, 8'hFF, 7'h7F, 8'hFF, 8'hFF, 10'h3FF, 8'hFF, 8'hFF,
			8'hFF, 11'h7FF, 0, 0, 0};
		reg_m = '{0, 0, 12'hBC6, 12'h001, 8'h03, 0, 0, 0, 10'h010, 8'h80, 8'h80, 8'h80, 0, 0, 0, 0};
		repeat (6) @(negedge ref_clk);
		resetn = 1'h1;
		// reset values, then random words over the whole map with reserved offsets among them
		for (int a = 0; a < 16; a++)
			rd(a);
		chk_static;
		repeat (4)
		begin
			for (int a = 0; a < 16; a++)
				wr(a, $random(seed));
			for (int a = 0; a < 16; a++)
				rd(a);
			nondestructive_sel = 1'($random(seed));
			chk_static;
		end
		// every lag code, nibbles kept apart
		for (int c = 0; c < 16; c++)
		begin
			wr(4, c * 16 + 15 - c);
			qualifier_raw = 1'h1;
			row_end_raw = 1'h1;
			dq = -1;
			de = -1;
			for (int k = 0; k < 16; k++)
			begin
				#1;
				if (sample_qualifier === 1'h1 && dq < 0)
					dq = k;
				if (row_end_pulse === 1'h1 && de < 0)
					de = k;
				@(negedge ref_clk);
				qualifier_raw = 1'h0;
				row_end_raw = 1'h0;
			end
			chk(16'(dq), 16'((15 - c) > 2 ? 13 - c : 0));
			chk(16'(de), 16'(c > 2 ? c - 2 : 0));
		end
		// normal readout frame of three rows, exposure of two
		nondestructive_sel = 1'h0;
		wr(2, 3);
		wr(3, 2);
		wr(4, 0);
		adv(1);
		chk(ops.left_load, 1'h1);
		for (int i = 1; i <= 3; i++)
		begin
			adv(0);
			chk({ops.read_left, ops.read_right, ops.row_reset}, 3'h5);
			chk(16'(pr - pa), 16'h0001);
			chk(16'(pb - pa), 16'h0002);
			chk(ops.right_pointer_load, i == 2);
			chk(fe, i == 3);
		end
		for (int m = 0; m < 4; m++)
		begin
			nondestructive_sel = 1'h1;
			nd_submode = 2'(m);
			adv(1);
			chk(ops.right_pointer_load, m < 2);
			for (int i = 0; i < 2; i++)
			begin
				adv(0);
				if (m < 2)
					chk({ops.both_sides, ops.row_reset}, {1'h1, m == 0});
				else
					chk({ops.read_left, ops.read_right, ops.row_reset},
						{i == 0, i == 1, m == 2 && i == 0});
			end
			chk(reset_bus_dark, 1'h1);
		end
		wrap_up();
	end
endmodule : test_sensor_readout_config_bank
